// ### rtl/ppei_port.v
`timescale 1ns/10ps
`include "ppei_map.vh"

module ppei_port
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire [7:0]  pin_pad_in,
  output reg         pin_wakeup_event
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [7:0]  pin_irq_enable;
  reg  [7:0]  pin_polarity;
  reg  [7:0]  pin_edge_flags;
  wire [7:0]  pin_edge_flag_bits;
  wire [7:0]  pin_level;
  reg  [7:0]  next_enable;
  reg  [7:0]  next_polarity;
  reg  [7:0]  next_flags;
  reg  [31:0] next_prdata;
  reg         next_pready;
  reg         next_pslverr;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  reg         hit_enable;
  reg         hit_polarity;
  reg         hit_flags;
  reg         hit_pins;
  reg         mapped;
  reg         wr_enable;
  reg         wr_polarity;
  reg         wr_flags;
  // Access is qualified by pready, so a master that holds penable past the
  // answer cannot make a write land twice.
  wire [7:0]  wr_byte  = pwdata[`PPEI_FIELD_MSB:`PPEI_FIELD_LSB];
  wire        setup    = psel & ~penable;
  wire        access   = psel & penable & pready;
  wire        wr_cycle = access & pwrite;
  wire        rd_setup = setup & ~pwrite;

  always @*
  begin
    hit_enable   = 1'b0;
    hit_polarity = 1'b0;
    hit_flags    = 1'b0;
    hit_pins     = 1'b0;
    case (paddr)
      `PPEI_OFS_ENABLE:
      begin
        hit_enable = 1'b1;
      end
      `PPEI_OFS_POLARITY:
      begin
        hit_polarity = 1'b1;
      end
      `PPEI_OFS_FLAGS:
      begin
        hit_flags = 1'b1;
      end
      `PPEI_OFS_PINS:
      begin
        hit_pins = 1'b1;
      end
      default:
      begin
        hit_pins = 1'b0;
      end
    endcase
    mapped = hit_enable | hit_polarity | hit_flags | hit_pins;
  end

  // Writes take effect only at the access edge; the pin level register is
  // read-only, so a write to it is dropped without an error.
  always @*
  begin
    wr_enable   = wr_cycle & hit_enable;
    wr_polarity = wr_cycle & hit_polarity;
    wr_flags    = wr_cycle & hit_flags;
  end

  // Zero wait states, yet pready and pslverr still come from flip-flops:
  // both are launched at the setup edge and stand for the one access cycle.
  always @*
  begin
    next_pready  = setup;
    next_pslverr = setup & ~mapped;
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PPEI_PIN_COUNT; gi = gi + 1)
    begin : g_pin
      ppei_edge_cell u_cell
      (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    (pin_pad_in[gi]),
        .rise_sel  (pin_polarity[gi]),
        .pin_level (pin_level[gi]),
        .edge_hit  (pin_edge_flag_bits[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  // per-pin enable
  always @*
  begin
    next_enable = pin_irq_enable;
    if (wr_enable)
    begin
      next_enable = wr_byte;
    end
  end

  always @*
  begin
    next_polarity = pin_polarity;
    if (wr_polarity)
    begin
      next_polarity = wr_byte;
    end
  end

  // A clear written in the same cycle as a new edge on that pin must not
  // lose the edge, so the set term is applied after the clear.
  // sticky flags, set beats clear
  always @*
  begin
    next_flags = pin_edge_flags;
    if (wr_flags)
    begin
      next_flags = pin_edge_flags & ~wr_byte;
    end
    next_flags = next_flags | pin_edge_flag_bits;
  end

  // Read data follows the setup address; unmapped offsets read as zero.
  always @*
  begin
    next_prdata = `PPEI_RST_RDATA;
    case (paddr)
      `PPEI_OFS_ENABLE:
      begin
        next_prdata[`PPEI_FIELD_MSB:`PPEI_FIELD_LSB] = pin_irq_enable;
      end
      `PPEI_OFS_POLARITY:
      begin
        next_prdata[`PPEI_FIELD_MSB:`PPEI_FIELD_LSB] = pin_polarity;
      end
      `PPEI_OFS_FLAGS:
      begin
        next_prdata[`PPEI_FIELD_MSB:`PPEI_FIELD_LSB] = pin_edge_flags;
      end
      // The agreed synchroniser level is returned, not the raw pad, so
      // software sees the same value that the edge logic compared against.
      `PPEI_OFS_PINS:
      begin
        next_prdata[`PPEI_FIELD_MSB:`PPEI_FIELD_LSB] = pin_level;
      end
      default:
      begin
        next_prdata = `PPEI_RST_RDATA;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // A polarity change cannot fake an edge: the detector compares the
  // synchronised level against the agreed level, not against the select.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_irq_enable <= `PPEI_RST_ENABLE;
    end
    else
    begin
      pin_irq_enable <= next_enable;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_polarity <= `PPEI_RST_POLARITY;
    end
    else
    begin
      pin_polarity <= next_polarity;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_edge_flags <= `PPEI_RST_FLAGS;
    end
    else
    begin
      pin_edge_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= `PPEI_RST_BIT;
    end
    else
    begin
      pready <= next_pready;
    end
  end

  // An unmapped access is refused with an error; the write is not applied
  // anywhere because no register strobe decodes that address.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pslverr <= `PPEI_RST_BIT;
    end
    else
    begin
      pslverr <= next_pslverr;
    end
  end

  // Read data is registered in setup so it is stable in the access phase.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= `PPEI_RST_RDATA;
    end
    else
    begin
      if (rd_setup)
      begin
        prdata <= next_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // The request uses the next flag and enable values, so it follows a
  // write to either register at the same edge instead of one cycle late.
  // masked flags ORed into one request
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_wakeup_event <= `PPEI_RST_BIT;
    end
    else
    begin
      pin_wakeup_event <= |(next_flags & next_enable);
    end
  end

endmodule // ppei_port

// ### inc/ppei_map.vh
`ifndef PPEI_MAP_VH
`define PPEI_MAP_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PPEI_OFS_ENABLE    12'h000
`define PPEI_OFS_POLARITY  12'h004
`define PPEI_OFS_FLAGS     12'h008
`define PPEI_OFS_PINS      12'h00c
// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define PPEI_PIN_COUNT     8
`define PPEI_FIELD_MSB     7
`define PPEI_FIELD_LSB     0
`define PPEI_RST_ENABLE    8'h00
`define PPEI_RST_POLARITY  8'h00
`define PPEI_RST_FLAGS     8'h00
`define PPEI_RST_RDATA     32'h0000_0000
`define PPEI_RST_BIT       1'b0
`endif

// ### rtl/ppei_edge_cell.v
`timescale 1ns/10ps
// ----------------------------------------------------------------
// One pin: three-stage synchroniser and active-edge detector
// ----------------------------------------------------------------
module ppei_edge_cell
(
  input  wire core_clk,
  input  wire rst_n,
  input  wire pin_in,
  input  wire rise_sel,
  output reg  pin_level,
  output wire edge_hit
);

  reg sync_a;
  reg sync_b;
  reg sync_c;

  // The first stage is read only by the second; a change counts once the
  // second and third stages agree, so the stable level is tracked here.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      sync_c    <= 1'b0;
      pin_level <= 1'b0;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c)
      begin
        pin_level <= sync_c;
      end
    end
  end

  // Edge is qualified against the agreed level, so a single-cycle glitch
  // that never reaches two matching stages does not raise a flag.
  assign edge_hit = (sync_b == sync_c) && (sync_c != pin_level) &&
                    (sync_c == rise_sel);

endmodule // ppei_edge_cell

// ### test/ppei_pins.sv
`timescale 1ns/10ps
module ppei_pins
(
  input  wire       core_clk,
  input  wire [7:0] drive,
  output reg  [7:0] pads
);
  // Pads move on the same clock edge that the synchroniser samples; it sees them one edge later.
  initial pads = 8'h00;
  always @(posedge core_clk) pads <= drive;
endmodule // ppei_pins

// ### test/ppei_port_properties.sv
`timescale 1ns/10ps
module ppei_props
(
  input wire        core_clk,
  input wire        rst_n,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire [7:0]  pin_pad_in,
  input wire        pin_wakeup_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  // Eight quiet cycles let the synchroniser and edge logic settle.
  sequence calm; $stable(pin_pad_in) [*8]; endsequence
  sequence clr_all; wr && paddr == 12'h008 && pwdata[7:0] == 8'hff; endsequence
  sequence mask_all; wr && paddr == 12'h000 && pwdata[7:0] == 8'h00; endsequence
  sequence pin_read; acc && !pwrite && paddr == 12'h00c; endsequence
  chk_ready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  chk_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  chk_bad_addr: assert property (acc && paddr > 12'h00c |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  chk_mask_off: assert property (mask_all |=> !pin_wakeup_event)
    else $error("request while all masked");
  chk_clear_all: assert property (calm ##0 clr_all |=> !pin_wakeup_event)
    else $error("request after full clear");
  chk_req_sticky: assert property (pin_wakeup_event && !wr |=> pin_wakeup_event)
    else $error("request dropped");
  chk_pin_level: assert property (calm ##0 pin_read |-> prdata[7:0] == pin_pad_in)
    else $error("pin level read wrong");
endmodule // ppei_props
bind ppei_port ppei_props u_props (.*);

// ### test/ppei_port_tb.sv
`timescale 1ns/10ps
module ppei_port_tb;
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [11:0] paddr = 12'h0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg  [7:0]  drive = 8'h00;
  reg  [31:0] rd;
  reg         er;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire [7:0]  pads;
  wire        irq;
  integer     error_cnt = 0;
  integer     n_checks = 0;
  always #20 core_clk = ~core_clk;
  ppei_pins pins (.core_clk(core_clk), .drive(drive), .pads(pads));
  ppei_port uut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_pad_in(pads), .pin_wakeup_event(irq));
  task stop_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // APB master: holds the request until pready is seen high
  // ----------------------------------------------------------------
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && i < 16)
    begin
      @(posedge core_clk);
      i = i + 1;
    end
    if (i == 16)
    begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_reset;
    xfer(0, 12'h008, 0);
    chk(rd, 0);
    xfer(0, 12'h010, 0);
    chk(er, 1);
    chk(rd, 0);
  endtask
  task t_edges;
    xfer(1, 12'h004, 32'h0f);
    xfer(1, 12'h000, 32'hff);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h0f);
    xfer(0, 12'h000, 0);
    chk(rd, 32'hff);
    drive <= 8'hff;
    repeat (8) @(posedge core_clk);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h0f);
    chk(irq, 1);
    drive <= 8'h00;
    repeat (8) @(posedge core_clk);
    xfer(0, 12'h008, 0);
    chk(rd, 32'hff);
    xfer(0, 12'h00c, 0);
    chk(rd, 0);
  endtask
  task t_clear;
    xfer(1, 12'h008, 32'h05);
    xfer(0, 12'h008, 0);
    chk(rd, 32'hfa);
    xfer(1, 12'h008, 32'hfa);
    xfer(0, 12'h008, 0);
    chk(rd, 0);
    chk(irq, 0);
  endtask
  task t_mask;
    xfer(1, 12'h000, 0);
    drive <= 8'h81;
    repeat (8) @(posedge core_clk);
    chk(irq, 0);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h01);
    xfer(1, 12'h000, 32'h01);
    xfer(0, 12'h00c, 0);
    chk(rd, 32'h81);
    chk(irq, 1);
    xfer(1, 12'h00c, 0);
    xfer(0, 12'h00c, 0);
    chk(rd, 32'h81);
    xfer(1, 12'h008, 32'hff);
    xfer(0, 12'h008, 0);
    chk(irq, 0);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_edges;
    t_clear;
    t_mask;
    stop_test;
  end
endmodule // ppei_port_tb
